/* File: core/rx_link_if.sv */
// link between the receive shifter and the status logic
`timescale 1ns/10ps
interface rx_link_if;
   import uart_rx_pkg::*;
   logic valid;
   logic [8:0] data;
   logic parityErr;
   logic frameErr;
   logic idle;
   logic enable;
   logic flush;
   mode_e mode;
   logic [15:0] divisor;
   modport rcv (input enable, flush, mode, divisor,
      output valid, data, parityErr, frameErr, idle);
   modport host (output enable, flush, mode, divisor,
      input valid, data, parityErr, frameErr, idle);
endinterface

/* File: core/uart_rx_fifo.sv */
// receive character fifo with flush
`timescale 1ns/10ps
module uart_rx_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic push,
   input wire logic [WIDTH-1:0] din,
   input wire logic pop,
   input wire logic flush,
   output logic [WIDTH-1:0] dout,
   output logic empty,
   output logic full
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   // pointers carry one extra bit to tell full from empty
   assign empty = (wrPtr == rdPtr);
   assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   assign dout = mem[rdPtr[AW-1:0]];
   // pointer update; flush discards everything stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (push && !full) wrPtr <= wrPtr + 1'b1;
         if (pop && !empty) rdPtr <= rdPtr + 1'b1;
      end
   end
   // storage has no reset, entries are only read once written
   always_ff @(posedge clk) begin
      if (push && !full && !flush) mem[wrPtr[AW-1:0]] <= din;
   end
endmodule

/* File: core/uart_rx_pkg.sv */
// shared constants and types for the receive status block
package uart_rx_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   // status and control field positions
   localparam int BIT_AVAIL = 0;
   localparam int BIT_OVERRUN = 1;
   localparam int BIT_FRAME = 2;
   localparam int BIT_PARITY = 3;
   localparam int BIT_IDLE = 4;
   localparam int BIT_ADDR_EN = 5;
   // configuration field positions
   localparam int CFG_ENABLE = 0;
   localparam int CFG_MODE_LO = 1;
   localparam int CFG_DIV_LO = 16;
   // interrupt status and mask layout
   localparam int IRQ_RX = 0;
   localparam int IRQ_OVERRUN = 1;
   localparam int IRQ_FRAME = 2;
   localparam int IRQ_PARITY = 3;
   localparam int IRQ_W = 4;
   // timing: clock rate and default line rate
   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD_DEFAULT = 115_200;
   localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [15:0] DIV_MIN = 16'h0004;
   localparam logic ENABLE_RESET = 1'b1;
   localparam logic ADDR_EN_RESET = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
   // character format selected by software
   typedef enum logic [1:0] {MODE_8N, MODE_8E, MODE_8O, MODE_9N} mode_e;
endpackage

/* File: core/uart_rx_shifter.sv */
// receive shift register: start, data, parity and stop detection
`timescale 1ns/10ps
module uart_rx_shifter (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rxPin,
   rx_link_if.rcv link
);
   import uart_rx_pkg::*;
   typedef enum {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP} rx_state_e;
   rx_state_e state;
   logic rxMeta;
   logic rxSync;
   logic [15:0] tick;
   logic [3:0] bitIdx;
   logic [8:0] shift;
   logic parAcc;
   logic parBad;
   logic [3:0] lastBit;
   logic hasParity;
   // the pin is asynchronous, two flops before any use
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
      end else begin
         rxMeta <= rxPin;
         rxSync <= rxMeta;
      end
   end
   assign lastBit = (link.mode == MODE_9N) ? 4'h8 : 4'h7;
   assign hasParity = (link.mode == MODE_8E) || (link.mode == MODE_8O);
   assign link.idle = (state == S_IDLE);
   // bit timing: half a bit to mid start, then one bit per sample
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         tick <= '0;
         bitIdx <= '0;
         shift <= '0;
         parAcc <= 1'b0;
         parBad <= 1'b0;
         link.valid <= 1'b0;
         link.data <= '0;
         link.parityErr <= 1'b0;
         link.frameErr <= 1'b0;
      end else if (link.flush || !link.enable) begin
         state <= S_IDLE;
         link.valid <= 1'b0;
      end else begin
         link.valid <= 1'b0;
         if (state != S_IDLE && tick != 16'h0000) begin
            tick <= tick - 16'h0001;
         end else begin
            case (state)
               S_IDLE: begin
                  if (!rxSync) begin
                     state <= S_START;
                     tick <= link.divisor >> 1;
                  end
               end
               S_START: begin
                  // a glitch shorter than half a bit is not a start
                  state <= rxSync ? S_IDLE : S_DATA;
                  tick <= link.divisor - 16'h0001;
                  bitIdx <= '0;
                  shift <= '0;
                  parAcc <= 1'b0;
                  parBad <= 1'b0;
               end
               S_DATA: begin
                  shift[bitIdx] <= rxSync;
                  parAcc <= parAcc ^ rxSync;
                  tick <= link.divisor - 16'h0001;
                  bitIdx <= bitIdx + 4'h1;
                  if (bitIdx == lastBit) state <= hasParity ? S_PARITY : S_STOP;
               end
               S_PARITY: begin
                  parBad <= (parAcc ^ rxSync) != (link.mode == MODE_8O);
                  tick <= link.divisor - 16'h0001;
                  state <= S_STOP;
               end
               S_STOP: begin
                  link.valid <= 1'b1;
                  link.data <= shift;
                  link.parityErr <= parBad;
                  link.frameErr <= !rxSync;
                  state <= S_IDLE;
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end
endmodule

/* File: core/uart_rx_status.sv */
// receive status and control block with apb access and interrupt
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
// Functional notes
// - address match enable acts only in 9-bit mode, keying on ninth bit one.
// - idle flag reads one while receiver idle, zero while receiving; writes ignored.
// - parity fault flag shows parity error of the fifo head character; read-only.
// - frame fault flag shows framing error of the fifo head character; read-only.
// - overrun flag set by hardware on buffer overflow, held until software clears.
// - clearing a set overrun flag empties the buffer and the shift register.
// - software can only clear the overrun flag; writing one is ignored.
// - data available flag reads one while the buffer holds an unread character.
module uart_rx_status #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxPin,
   output logic irq
);
   import uart_rx_pkg::*;
   localparam int ENTRY_W = 11;

   // true for every offset that a register answers at
   function automatic logic isMapped(input logic [7:0] addr);
      return (addr == OFF_STATUS) || (addr == OFF_CONFIG) || (addr == OFF_DATA) ||
         (addr == OFF_IRQ_STATUS) || (addr == OFF_IRQ_MASK);
   endfunction

   rx_link_if link ();

   logic rxEnable;
   mode_e mode;
   logic [15:0] divisor;
   logic addrEnable;
   logic overrun;
   logic [IRQ_W-1:0] irqStatus;
   logic [IRQ_W-1:0] irqMask;
   logic setupPhase;
   logic wrAccess;
   logic rdAccess;
   logic nineBit;
   logic addrDetect;
   logic keepChar;
   logic push;
   logic pop;
   logic overrunEvt;
   logic overrunClear;
   logic fifoEmpty;
   logic fifoFull;
   logic [ENTRY_W-1:0] head;
   logic headParityBad;
   logic headFrameBad;
   logic [31:0] statusWord;
   logic [31:0] next_prdata;
   logic [IRQ_W-1:0] irqEvents;
   logic [15:0] wrDivisor;

   uart_rx_shifter u_shifter (
      .clk(clk),
      .reset_n(reset_n),
      .rxPin(rxPin),
      .link(link.rcv)
   );

   uart_rx_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .push(push),
      .din({link.frameErr, link.parityErr, link.data}),
      .pop(pop),
      .flush(overrunClear),
      .dout(head),
      .empty(fifoEmpty),
      .full(fifoFull)
   );

   // apb phases; the slave never inserts wait states
   assign setupPhase = psel && !penable;
   assign wrAccess = psel && penable && pwrite;
   assign rdAccess = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !isMapped(paddr);

   // settings handed to the shifter
   assign link.enable = rxEnable;
   assign link.mode = mode;
   assign link.divisor = divisor;
   assign link.flush = overrunClear;

   assign nineBit = (mode == MODE_9N);
   assign addrDetect = addrEnable && nineBit;

   assign keepChar = link.valid && (!addrDetect || link.data[8]);

   // a full buffer refuses the new character and flags overrun
   assign push = keepChar && !fifoFull;
   assign overrunEvt = keepChar && fifoFull;

   // one to zero transition of overrun
   // a new overrun in the same cycle wins, so no clear and no flush then
   assign overrunClear = wrAccess && (paddr == OFF_STATUS) && !pwdata[BIT_OVERRUN] &&
      overrun && !overrunEvt;

   // reading the data register consumes the head character
   assign pop = rdAccess && (paddr == OFF_DATA) && !fifoEmpty;

   assign headParityBad = head[9] && !fifoEmpty;
   assign headFrameBad = head[10] && !fifoEmpty;

   // status word; unimplemented bits read as zero
   always_comb begin
      statusWord = '0;
      statusWord[BIT_AVAIL] = !fifoEmpty;
      statusWord[BIT_OVERRUN] = overrun;
      statusWord[BIT_FRAME] = headFrameBad;
      statusWord[BIT_PARITY] = headParityBad;
      statusWord[BIT_IDLE] = link.idle;
      statusWord[BIT_ADDR_EN] = addrEnable;
   end

   // read mux; sampled in the setup cycle so prdata is a flop in access
   always_comb begin
      next_prdata = '0;
      case (paddr)
         OFF_STATUS: next_prdata = statusWord;
         OFF_CONFIG: begin
            next_prdata[CFG_ENABLE] = rxEnable;
            next_prdata[CFG_MODE_LO +: 2] = mode;
            next_prdata[CFG_DIV_LO +: 16] = divisor;
         end
         OFF_DATA: next_prdata[8:0] = fifoEmpty ? 9'h000 : head[8:0];
         OFF_IRQ_STATUS: next_prdata[IRQ_W-1:0] = irqStatus;
         OFF_IRQ_MASK: next_prdata[IRQ_W-1:0] = irqMask;
         default: next_prdata = '0;
      endcase
   end

   // read data register, loaded at setup and held through access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= '0;
      end else if (setupPhase && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // too small a divisor leaves no room for mid-bit sampling
   assign wrDivisor = (pwdata[CFG_DIV_LO +: 16] < DIV_MIN) ? DIV_MIN :
      pwdata[CFG_DIV_LO +: 16];

   // configuration register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rxEnable <= ENABLE_RESET;
         mode <= MODE_8N;
         divisor <= DIV_RESET;
      end else if (wrAccess && (paddr == OFF_CONFIG)) begin
         rxEnable <= pwdata[CFG_ENABLE];
         mode <= mode_e'(pwdata[CFG_MODE_LO +: 2]);
         divisor <= wrDivisor;
      end
   end

   // address match enable is the only plain writable status bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addrEnable <= ADDR_EN_RESET;
      end else if (wrAccess && (paddr == OFF_STATUS)) begin
         addrEnable <= pwdata[BIT_ADDR_EN];
      end
   end

   // only a clear is honoured, a written one changes nothing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overrun <= 1'b0;
      end else if (overrunEvt) begin
         overrun <= 1'b1;
      end else if (overrunClear) begin
         overrun <= 1'b0;
      end
   end

   // events feeding the interrupt status
   always_comb begin
      irqEvents = '0;
      irqEvents[IRQ_RX] = push;
      irqEvents[IRQ_OVERRUN] = overrunEvt;
      irqEvents[IRQ_FRAME] = push && link.frameErr;
      irqEvents[IRQ_PARITY] = push && link.parityErr;
   end

   // sticky interrupt status, write one to clear, events win over clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqStatus <= '0;
      end else if (wrAccess && (paddr == OFF_IRQ_STATUS)) begin
         irqStatus <= (irqStatus & ~pwdata[IRQ_W-1:0]) | irqEvents;
      end else begin
         irqStatus <= irqStatus | irqEvents;
      end
   end

   // interrupt mask register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqMask <= IRQ_MASK_RESET;
      end else if (wrAccess && (paddr == OFF_IRQ_MASK)) begin
         irqMask <= pwdata[IRQ_W-1:0];
      end
   end

   // level interrupt; a flop so the pin never glitches
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irqStatus | irqEvents) & irqMask);
      end
   end

   // checks on the status logic
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_overrun_set_full: assert property (
      keepChar && fifoFull |=> overrun)
      else $error("overrun not set when a character met a full buffer");

   a_overrun_held: assert property (
      overrun && !(wrAccess && paddr == OFF_STATUS) |=> overrun)
      else $error("overrun dropped without a software clear");

   a_overrun_one_ignored: assert property (
      !overrun && !overrunEvt && wrAccess && paddr == OFF_STATUS &&
      pwdata[BIT_OVERRUN] |=> !overrun)
      else $error("writing one set the overrun flag");

   a_clear_empties_all: assert property (
      overrunClear |=> fifoEmpty && link.idle && !overrun)
      else $error("overrun clear did not empty buffer and shifter");

   a_clear_only_when_set: assert property (
      $fell(overrun) |-> $past(wrAccess) && $past(paddr) == OFF_STATUS)
      else $error("overrun fell without a status write");

   a_avail_reads_back: assert property (
      setupPhase && !pwrite && paddr == OFF_STATUS |=>
      prdata[BIT_AVAIL] == $past(!fifoEmpty))
      else $error("available flag does not follow the buffer");

   a_avail_after_push: assert property (
      push && !overrunClear |=> !fifoEmpty)
      else $error("buffer empty after a character was stored");

   a_idle_reads_back: assert property (
      setupPhase && !pwrite && paddr == OFF_STATUS |=>
      prdata[BIT_IDLE] == $past(link.idle) && prdata[7:6] == 2'b00)
      else $error("idle flag read does not match the shifter");

   a_parity_of_head: assert property (
      setupPhase && !pwrite && paddr == OFF_STATUS |=>
      prdata[BIT_PARITY] == $past(head[9] && !fifoEmpty))
      else $error("parity fault flag does not match the head character");

   a_frame_of_head: assert property (
      setupPhase && !pwrite && paddr == OFF_STATUS |=>
      prdata[BIT_FRAME] == $past(head[10] && !fifoEmpty))
      else $error("frame fault flag does not match the head character");

   a_non_address_dropped: assert property (
      link.valid && addrDetect && !link.data[8] |-> !push && !overrunEvt)
      else $error("non-address character stored in address detect mode");

   a_nine_bit_only: assert property (
      link.valid && !nineBit && !fifoFull |-> push)
      else $error("address enable filtered outside nine-bit mode");

   a_irq_follows_mask: assert property (
      (irqStatus & irqMask) != '0 |=> irq)
      else $error("interrupt low while an unmasked status bit is set");

   // further checks on read data, stored flags and refused writes
   a_prdata_held: assert property (
      !(setupPhase && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read setup cycle");

   a_data_reads_head: assert property (
      setupPhase && !pwrite && paddr == OFF_DATA |=> prdata[31:9] == 23'h0 &&
      prdata[8:0] == ($past(fifoEmpty) ? 9'h000 : $past(head[8:0])))
      else $error("data register read does not show the head character");

   a_addr_en_written: assert property (
      wrAccess && paddr == OFF_STATUS |=> addrEnable == $past(pwdata[BIT_ADDR_EN]))
      else $error("address match enable did not take the written value");

   a_unmapped_no_effect: assert property (
      pslverr && pwrite |=> $stable(addrEnable) && $stable(irqMask) &&
      $stable(divisor) && $stable(mode) && $stable(rxEnable))
      else $error("write to an unmapped offset changed a register");

   a_flush_drops_valid: assert property (
      overrunClear |=> !link.valid)
      else $error("shift register delivered a character after the flush");

   a_head_frame_stored: assert property (
      push && fifoEmpty && !overrunClear |=> headFrameBad == $past(link.frameErr))
      else $error("frame fault flag lost when the character was stored");

   a_head_parity_stored: assert property (
      push && fifoEmpty && !overrunClear |=> headParityBad == $past(link.parityErr))
      else $error("parity fault flag lost when the character was stored");

   a_status_write_keeps_fifo: assert property (
      wrAccess && paddr == OFF_STATUS && !push && !overrunClear |=>
      fifoEmpty == $past(fifoEmpty))
      else $error("writing the status register changed the buffer");

   a_overrun_needs_full: assert property (
      $rose(overrun) |-> $past(keepChar && fifoFull))
      else $error("overrun set without a buffer overflow");

   c_overrun_seen: cover property (overrunEvt);
   c_overrun_cleared: cover property (overrun ##[1:50] overrunClear);
   c_address_dropped: cover property (link.valid && addrDetect && !link.data[8]);
   c_char_read: cover property (push ##[1:1000] pop);
   c_frame_fault: cover property (push && link.frameErr);
endmodule

/* File: dv/uart_line_model.sv */
// serial transmitter model that drives the receive line
`timescale 1ns/10ps
module uart_line_model #(
   parameter int BIT_CYC = 9
) (
   input wire logic clk,
   output logic line
);
   // the line idles high between frames, as a real transmitter holds it
   initial begin
      line = 1'b1;
   end
   // one bit: change just after the edge, hold for a full bit time
   task automatic drive(input logic b);
      line <= b;
      repeat (BIT_CYC) @(posedge clk);
   endtask
   // one frame, lsb first; stop level and parity are chosen by the caller
   // so that broken frames can be commanded on purpose
   task automatic send(input logic [8:0] ch, input int nbits, input logic parEn,
      input logic parBit, input logic stopLvl);
      drive(1'b0);
      for (int i = 0; i < nbits; i++) begin
         drive(ch[i]);
      end
      if (parEn) begin
         drive(parBit);
      end
      drive(stopLvl);
      // one idle bit so a low stop never runs into the next start
      drive(1'b1);
   endtask
endmodule

/* File: dv/uart_rx_status_bench.sv */
// self-checking bench for the receive status block
`timescale 1ns/10ps
module uart_rx_status_bench;
   import uart_rx_pkg::*;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rxLine, irq, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int err_total = 0;
   int total_checks = 0;

   uart_rx_status #(.FIFO_DEPTH(4)) i_uart_rx_status (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxLine), .irq(irq));
   // the shifter reloads divisor-1 and acts on zero, so divisor 8 gives eight clocks per bit
   uart_line_model #(.BIT_CYC(8)) i_uart_line_model (.clk(clk), .line(rxLine));

   // 20 MHz clock
   always #25 clk = ~clk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic timeout(input string msg);
      err_total++;
      $display("wrong value at %0t: %s timed out", $time, msg);
      summarize();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) timeout("apb");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps psel from being driven twice in one step
      @(posedge clk);
   endtask
   task automatic rdck(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rdat, exp, msg);
   endtask
   // poll status until a flag shows, bounded
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while ((rdat & m) == 0 && n < 60);
      if (n >= 60) timeout("status poll");
   endtask
   function automatic logic [31:0] cfgw(input logic [1:0] m);
      return {16'h0008, 13'h0, m, 1'b1};
   endfunction
   task automatic irqck(input logic exp, input string msg);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, {31'h0, exp}, msg);
      @(posedge clk);
   endtask

   task automatic t_reset();
      rdck(OFF_STATUS, 32'h0000_0010, "status reset");
      // a write to an unmapped offset is refused and changes nothing
      apb(1'b1, 8'h14, 32'hffff_ffff);
      check({31'h0, rerr}, 32'h1, "unmapped write error");
      rdck(OFF_CONFIG, {DIV_RESET, 13'h0, 2'b00, ENABLE_RESET}, "config reset");
      rdck(OFF_IRQ_MASK, 32'h0, "mask reset");
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, rerr}, 32'h1, "unmapped error");
      check(rdat, 32'h0, "unmapped data");
      irqck(1'b0, "irq reset");
      $display("done: reset");
   endtask
   task automatic t_char();
      apb(1'b1, OFF_CONFIG, cfgw(2'd0));
      // read-only flags and overrun ignore written ones
      apb(1'b1, OFF_STATUS, 32'h0000_001f);
      rdck(OFF_STATUS, 32'h0000_0010, "ro write");
      fork
         i_uart_line_model.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
         begin
            repeat (20) @(posedge clk);
            rdck(OFF_STATUS, 32'h0000_0000, "busy idle");
         end
      join
      poll(32'h1);
      check(rdat, 32'h0000_0011, "avail set");
      rdck(OFF_DATA, 32'h0000_00a5, "char data");
      rdck(OFF_STATUS, 32'h0000_0010, "avail clear");
      $display("done: char");
   endtask
   task automatic t_errors();
      apb(1'b1, OFF_CONFIG, cfgw(2'd1));
      // bad even parity on the first, low stop on the second
      i_uart_line_model.send(9'h03c, 8, 1'b1, 1'b1, 1'b1);
      i_uart_line_model.send(9'h081, 8, 1'b1, 1'b0, 1'b0);
      poll(32'h1);
      rdck(OFF_STATUS, 32'h0000_0019, "parity head");
      rdck(OFF_DATA, 32'h0000_003c, "parity data");
      rdck(OFF_STATUS, 32'h0000_0015, "frame head");
      rdck(OFF_DATA, 32'h0000_0081, "frame data");
      rdck(OFF_STATUS, 32'h0000_0010, "flags clear");
      $display("done: errors");
   endtask
   task automatic t_overrun();
      apb(1'b1, OFF_CONFIG, cfgw(2'd0));
      apb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
      for (int i = 0; i < 5; i++) begin
         i_uart_line_model.send(9'h010 + 9'(i), 8, 1'b0, 1'b0, 1'b1);
      end
      poll(32'h2);
      rdck(OFF_STATUS, 32'h0000_0013, "overrun set");
      irqck(1'b1, "irq overrun");
      apb(1'b1, OFF_STATUS, 32'h0000_0002);
      rdck(OFF_STATUS, 32'h0000_0013, "overrun held");
      apb(1'b1, OFF_STATUS, 32'h0000_0000);
      rdck(OFF_STATUS, 32'h0000_0010, "flushed");
      rdck(OFF_DATA, 32'h0000_0000, "empty data");
      apb(1'b1, OFF_IRQ_STATUS, 32'h0000_000f);
      rdck(OFF_IRQ_STATUS, 32'h0, "irq cleared");
      irqck(1'b0, "irq low");
      $display("done: overrun");
   endtask
   task automatic t_addr();
      apb(1'b1, OFF_CONFIG, cfgw(2'd3));
      apb(1'b1, OFF_STATUS, 32'h0000_0020);
      rdck(OFF_STATUS, 32'h0000_0030, "addr enable");
      i_uart_line_model.send(9'h055, 9, 1'b0, 1'b0, 1'b1);
      i_uart_line_model.send(9'h1aa, 9, 1'b0, 1'b0, 1'b1);
      poll(32'h1);
      rdck(OFF_DATA, 32'h0000_01aa, "address kept");
      rdck(OFF_STATUS, 32'h0000_0030, "data dropped");
      // outside nine-bit mode the enable has no effect
      apb(1'b1, OFF_CONFIG, cfgw(2'd0));
      i_uart_line_model.send(9'h055, 8, 1'b0, 1'b0, 1'b1);
      poll(32'h1);
      rdck(OFF_DATA, 32'h0000_0055, "plain kept");
      $display("done: address");
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_char();
      t_errors();
      t_overrun();
      t_addr();
      summarize();
   end
endmodule
